//--- logic/mau_pkg.sv
// Purpose: shared constants and types for the multiply/accumulate unit
// Assumes: 32-bit operands, 32-entry general register file
// Notes:   state codes are one-hot; operation codes are plain binary
package mau_pkg;
  localparam int unsigned MAU_DATA_W  = 32;
  localparam int unsigned MAU_PAIR_W  = 64;
  localparam int unsigned MAU_REG_W   = 5;
  localparam int unsigned MAU_DIV_CYC = 32;
  localparam logic [31:0] MAU_TOP_RST = 32'h0000_0000;
  localparam logic [31:0] MAU_BOT_RST = 32'h0000_0000;

  typedef enum logic [3:0]
  {
    MAU_OP_MULT = 4'h0,
    MAU_OP_MULTU = 4'h1,
    MAU_OP_DIV = 4'h2,
    MAU_OP_DIVU = 4'h3,
    MAU_OP_READ_TOP = 4'h4,
    MAU_OP_READ_BOT = 4'h5,
    MAU_OP_DIRECT = 4'h6,
    MAU_OP_ADD = 4'h7,
    MAU_OP_SUB = 4'h8,
    MAU_OP_WRITE_TOP = 4'h9,
    MAU_OP_WRITE_BOT = 4'ha
  } mau_op_e;

  typedef enum logic [1:0]
  {
    MAU_ST_IDLE = 2'b01,
    MAU_ST_DIV  = 2'b10
  } mau_state_e;
endpackage

//--- logic/mau_divider.sv
// Purpose: iterative restoring divider, one quotient bit per cycle
// Assumes: start pulses only while not busy
// Notes:   divide by zero yields all-ones quotient, dividend as remainder
`timescale 1ns/1ps
module mau_divider
  import mau_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  start,
  input  wire logic                  is_signed,
  input  wire logic [MAU_DATA_W-1:0] dividend,
  input  wire logic [MAU_DATA_W-1:0] divisor,
  output logic                       done,
  output logic      [MAU_DATA_W-1:0] quotient,
  output logic      [MAU_DATA_W-1:0] remainder
);
  typedef struct packed
  {
    logic        busy;
    logic [5:0]  cnt;
    logic [31:0] q;
    logic [32:0] r;
    logic [31:0] d;
    logic        neg_q;
    logic        neg_r;
    logic        done;
    logic [31:0] quo;
    logic [31:0] rem;
  } mau_div_s;

  mau_div_s st_ff;
  mau_div_s nxt_st;

  function automatic logic [31:0] mau_abs(input logic [31:0] v,
                                          input logic en);
    mau_abs = (en && v[31]) ? 32'(-v) : v;
  endfunction

  always_comb
  begin
    logic [32:0] trial;
    trial = 33'h0;
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (start && !st_ff.busy)
    begin
      nxt_st.busy  = 1'b1;
      nxt_st.cnt   = 6'(MAU_DIV_CYC);
      nxt_st.q     = mau_abs(dividend, is_signed);
      nxt_st.d     = mau_abs(divisor, is_signed);
      nxt_st.r     = 33'h0;
      nxt_st.neg_q = is_signed && (dividend[31] ^ divisor[31])
                     && (divisor != 32'h0);
      nxt_st.neg_r = is_signed && dividend[31];
    end
    else if (st_ff.busy)
    begin
      trial = {st_ff.r[31:0], st_ff.q[31]} - {1'b0, st_ff.d};
      if (!trial[32])
      begin
        nxt_st.r = trial;
        nxt_st.q = {st_ff.q[30:0], 1'b1};
      end
      else
      begin
        nxt_st.r = {st_ff.r[31:0], st_ff.q[31]};
        nxt_st.q = {st_ff.q[30:0], 1'b0};
      end
      nxt_st.cnt = st_ff.cnt - 6'h01;
      if (st_ff.cnt == 6'h01)
      begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
        nxt_st.quo  = st_ff.neg_q ? 32'(-nxt_st.q) : nxt_st.q;
        nxt_st.rem  = st_ff.neg_r ? 32'(-nxt_st.r[31:0])
                                  : nxt_st.r[31:0];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign done      = st_ff.done;
  assign quotient  = st_ff.quo;
  assign remainder = st_ff.rem;
endmodule

//--- logic/mau_core.sv
// Purpose: multiply, divide and accumulate datapath with result pair
// Assumes: the pipeline holds op_valid until op_ready is high
// Notes:   one operation taken per cycle, results one cycle later, divide results 34 cycles later
// Notes on behaviour
// - multiply and divide results go to pair
// - read ops copy pair word to register
// - direct product writes low word to register
// - direct product may target any register
// - multiply-add adds product into the pair
// - multiply-subtract removes product from the pair
`timescale 1ns/1ps
module mau_core
  import mau_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  op_valid,
  input  wire logic [3:0]            op_code,
  input  wire logic                  op_signed,
  input  wire logic [MAU_DATA_W-1:0] src_a,
  input  wire logic [MAU_DATA_W-1:0] src_b,
  input  wire logic [MAU_REG_W-1:0]  dest_reg,
  output logic                       op_ready,
  output logic                       gpr_we,
  output logic      [MAU_REG_W-1:0]  gpr_addr,
  output logic      [MAU_DATA_W-1:0] gpr_wdata,
  output logic      [MAU_DATA_W-1:0] accum_top_word,
  output logic      [MAU_DATA_W-1:0] accum_bottom_word
);
  typedef struct packed
  {
    mau_state_e  state;
    logic        ready;
    logic        we;
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic [63:0] pair;
  } mau_core_s;

  mau_core_s st_ff;
  mau_core_s nxt_st;

  logic        div_start;
  logic        div_done;
  logic [31:0] div_quo;
  logic [31:0] div_rem;

  // both multiplier forms share this one function
  function automatic logic [63:0] mau_prod(input logic [31:0] a,
                                           input logic [31:0] b,
                                           input logic sgn);
    logic [63:0] ea;
    logic [63:0] eb;
    ea = sgn ? {{32{a[31]}}, a} : {32'h0, a};
    eb = sgn ? {{32{b[31]}}, b} : {32'h0, b};
    mau_prod = 64'(ea * eb);
  endfunction

  mau_divider mau_divider_inst
  (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .start     (div_start),
    .is_signed (op_code == MAU_OP_DIV),
    .dividend  (src_a),
    .divisor   (src_b),
    .done      (div_done),
    .quotient  (div_quo),
    .remainder (div_rem)
  );

  logic take;
  assign take = op_valid && st_ff.ready;
  assign div_start = take && (op_code == MAU_OP_DIV
                              || op_code == MAU_OP_DIVU);

  always_comb
  begin
    logic [63:0] prod;
    prod = mau_prod(src_a, src_b, op_signed);
    nxt_st = st_ff;
    nxt_st.we = 1'b0;
    unique case (st_ff.state)
      MAU_ST_IDLE:
      begin
        if (take)
        begin
          case (op_code)
            MAU_OP_MULT, MAU_OP_MULTU:
              nxt_st.pair = mau_prod(src_a, src_b,
                                     op_code == MAU_OP_MULT);
            MAU_OP_DIV, MAU_OP_DIVU:
            begin
              // pipeline stalls rather than track a pending divide
              nxt_st.state = MAU_ST_DIV;
              nxt_st.ready = 1'b0;
            end
            MAU_OP_READ_TOP, MAU_OP_READ_BOT:
            begin
              nxt_st.we    = 1'b1;
              nxt_st.addr  = dest_reg;
              nxt_st.wdata = (op_code == MAU_OP_READ_TOP)
                             ? st_ff.pair[63:32] : st_ff.pair[31:0];
            end
            MAU_OP_DIRECT:
            begin
              // pair is left untouched by the direct product
              nxt_st.we    = 1'b1;
              nxt_st.addr  = dest_reg;
              nxt_st.wdata = prod[31:0];
            end
            MAU_OP_ADD:
              nxt_st.pair = 64'(st_ff.pair + prod);
            MAU_OP_SUB:
              nxt_st.pair = 64'(st_ff.pair - prod);
            MAU_OP_WRITE_TOP:
              nxt_st.pair[63:32] = src_a;
            MAU_OP_WRITE_BOT:
              nxt_st.pair[31:0] = src_a;
            default:
              nxt_st.pair = st_ff.pair;
          endcase
        end
      end
      MAU_ST_DIV:
      begin
        if (div_done)
        begin
          nxt_st.pair  = {div_rem, div_quo};
          nxt_st.state = MAU_ST_IDLE;
          nxt_st.ready = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_ff       <= '0;
      st_ff.state <= MAU_ST_IDLE;
      st_ff.ready <= 1'b1;
      st_ff.pair  <= {MAU_TOP_RST, MAU_BOT_RST};
    end
    else
      st_ff <= nxt_st;
  end

  assign op_ready          = st_ff.ready;
  assign gpr_we            = st_ff.we;
  assign gpr_addr          = st_ff.addr;
  assign gpr_wdata         = st_ff.wdata;
  assign accum_top_word    = st_ff.pair[63:32];
  assign accum_bottom_word = st_ff.pair[31:0];

  sequence s_take(logic [3:0] c);
    op_valid && op_ready && op_code == c;
  endsequence

  // a divide answers a fixed count after the take, no handshake back
  sequence s_div_back;
    ##33 op_ready;
  endsequence

  a_mult_to_pair: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_MULTU) |=> {accum_top_word, accum_bottom_word}
      == $past(src_a) * $past(src_b) && !gpr_we)
    else $error("unsigned multiply result not in pair");
  a_read_top_copy: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_READ_TOP) |=> gpr_we && gpr_addr == $past(dest_reg)
      && gpr_wdata == $past(accum_top_word))
    else $error("read of top word wrong");
  a_read_bot_copy: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_READ_BOT) |=> gpr_we && gpr_addr == $past(dest_reg)
      && gpr_wdata == $past(accum_bottom_word))
    else $error("read of bottom word wrong");
  a_direct_low_word: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_DIRECT) |=> gpr_we
      && gpr_wdata == 32'($past(src_a) * $past(src_b))
      && $stable(accum_bottom_word))
    else $error("direct product low word wrong");
  a_direct_any_dest: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_DIRECT) |=> gpr_addr == $past(dest_reg))
    else $error("direct product destination wrong");
  a_add_accum: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_ADD) |=> {accum_top_word, accum_bottom_word}
      == 64'({$past(accum_top_word), $past(accum_bottom_word)}
      + mau_prod($past(src_a), $past(src_b), $past(op_signed))))
    else $error("multiply-add sum wrong");
  a_sub_accum: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_SUB) |=> {accum_top_word, accum_bottom_word}
      == 64'({$past(accum_top_word), $past(accum_bottom_word)}
      - mau_prod($past(src_a), $past(src_b), $past(op_signed))))
    else $error("multiply-subtract difference wrong");
  a_signed_wide: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_MULT) ##0 (src_a == 32'hffff_ffff)
      ##0 (src_b == 32'h0000_0002)
      |=> accum_top_word == 32'hffff_ffff
      && accum_bottom_word == 32'hffff_fffe)
    else $error("signed product not double width");
  a_mult_signed: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_MULT) |=> {accum_top_word, accum_bottom_word}
      == 64'($signed($past(src_a)) * $signed($past(src_b))))
    else $error("signed product wrong");
  a_div_stall: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_DIVU) |=> !op_ready [*8])
    else $error("divide did not stall");
  a_div_result: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_take(MAU_OP_DIVU) ##0 (src_b != 32'h0) |=> s_div_back
      ##0 (accum_bottom_word == $past(src_a, 34) / $past(src_b, 34)
      && accum_top_word == $past(src_a, 34) % $past(src_b, 34)))
    else $error("divide result not in pair");
  a_busy_refused: assert property (
    @(posedge ref_clk) disable iff (rst)
    !op_ready && !div_done |=> $stable({accum_top_word, accum_bottom_word})
      && !gpr_we)
    else $error("pair or register changed while divide busy");
  a_we_source: assert property (
    @(posedge ref_clk) disable iff (rst)
    gpr_we |-> $past(op_valid && op_ready
      && (op_code == MAU_OP_READ_TOP || op_code == MAU_OP_READ_BOT
      || op_code == MAU_OP_DIRECT)))
    else $error("register write without a read or direct op");
endmodule

//--- tb/mau_gpr_model.sv
// Purpose: register file model on the pipeline side of the unit
// Assumes: one write per cycle, taken on the rising edge
// Notes:   entries start at a marker so a missed write shows up
`timescale 1ns/1ps
module mau_gpr_model
  import mau_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  gpr_we,
  input wire logic [MAU_REG_W-1:0]  gpr_addr,
  input wire logic [MAU_DATA_W-1:0] gpr_wdata
);
  logic [MAU_DATA_W-1:0] regs [32];

  initial
  begin
    foreach (regs[i])
      regs[i] = 32'h5a5a_5a5a;
  end

  always @(posedge ref_clk)
  begin
    if (gpr_we === 1'b1)
      regs[gpr_addr] <= gpr_wdata;
  end
endmodule

//--- tb/tb_mau_core.sv
// Purpose: self-checking bench for the multiply/accumulate unit
// Assumes: one request held until op_ready is seen high
// Notes:   results are read 1 ns after a clock edge at or after the one that updates them
`timescale 1ns/1ps
module tb_mau_core
  import mau_pkg::*;
;
  logic        ref_clk, rst, op_valid, op_signed, op_ready, gpr_we;
  logic [3:0]  op_code;
  logic [31:0] src_a, src_b, gpr_wdata, top, bot;
  logic [4:0]  dest_reg, gpr_addr;
  int          fails, check_count;

  mau_core mau_core_inst (.ref_clk(ref_clk), .rst(rst),
    .op_valid(op_valid), .op_code(op_code), .op_signed(op_signed),
    .src_a(src_a), .src_b(src_b), .dest_reg(dest_reg),
    .op_ready(op_ready), .gpr_we(gpr_we), .gpr_addr(gpr_addr),
    .gpr_wdata(gpr_wdata), .accum_top_word(top),
    .accum_bottom_word(bot));
  mau_gpr_model mau_gpr_model_inst (.ref_clk(ref_clk), .gpr_we(gpr_we),
    .gpr_addr(gpr_addr), .gpr_wdata(gpr_wdata));

  task automatic chk32(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // valid stays up so back-to-back calls never assign it twice per step
  task automatic issue(input mau_op_e op, input logic s,
                       input logic [31:0] a, b, input logic [4:0] d);
    int n;
    op_valid  <= 1'b1;
    op_code   <= op;
    op_signed <= s;
    src_a     <= a;
    src_b     <= b;
    dest_reg  <= d;
    for (n = 0; n < 50; n++)
    begin
      @(posedge ref_clk);
      if (op_ready === 1'b1)
        break;
    end
    if (n == 50)
    begin
      fails++;
      close_out();
    end
  endtask

  task automatic idle;
    op_valid <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic pair(input logic [31:0] t, b);
    chk32("top", t, top);
    chk32("bot", b, bot);
  endtask

  task automatic t_mult;
    @(posedge ref_clk);
    issue(MAU_OP_MULT, 1'b0, 32'hffff_fffd, 32'h0000_0005, 5'h00);
    idle();
    pair(32'hffff_ffff, 32'hffff_fff1);
    @(posedge ref_clk);
    issue(MAU_OP_MULT, 1'b1, 32'hffff_ffff, 32'h0000_0002, 5'h00);
    idle();
    pair(32'hffff_ffff, 32'hffff_fffe);
    @(posedge ref_clk);
    issue(MAU_OP_MULTU, 1'b0, 32'hffff_ffff, 32'hffff_ffff, 5'h00);
    idle();
    pair(32'hffff_fffe, 32'h0000_0001);
  endtask

  task automatic t_moves;
    @(posedge ref_clk);
    issue(MAU_OP_READ_TOP, 1'b0, 32'h0, 32'h0, 5'h03);
    issue(MAU_OP_READ_BOT, 1'b0, 32'h0, 32'h0, 5'h04);
    issue(MAU_OP_DIRECT, 1'b1, 32'hffff_fffe, 32'h0000_0003, 5'h01);
    issue(MAU_OP_DIRECT, 1'b0, 32'h0001_0001, 32'h0001_0001, 5'h1f);
    idle();
    @(posedge ref_clk);
    #1;
    chk32("r3", 32'hffff_fffe, mau_gpr_model_inst.regs[3]);
    chk32("r4", 32'h0000_0001, mau_gpr_model_inst.regs[4]);
    chk32("r1", 32'hffff_fffa, mau_gpr_model_inst.regs[1]);
    chk32("r31", 32'h0002_0001, mau_gpr_model_inst.regs[31]);
    pair(32'hffff_fffe, 32'h0000_0001);
  endtask

  task automatic t_accum;
    @(posedge ref_clk);
    issue(MAU_OP_WRITE_TOP, 1'b0, 32'h0, 32'h0, 5'h00);
    issue(MAU_OP_WRITE_BOT, 1'b0, 32'hffff_ffff, 32'h0, 5'h00);
    issue(MAU_OP_ADD, 1'b0, 32'h0000_0001, 32'h0000_0001, 5'h00);
    idle();
    pair(32'h0000_0001, 32'h0000_0000);
    @(posedge ref_clk);
    issue(MAU_OP_SUB, 1'b0, 32'h0000_0001, 32'h0000_0002, 5'h00);
    idle();
    pair(32'h0000_0000, 32'hffff_fffe);
    @(posedge ref_clk);
    issue(MAU_OP_ADD, 1'b1, 32'hffff_ffff, 32'h0000_0001, 5'h00);
    idle();
    pair(32'h0000_0000, 32'hffff_fffd);
  endtask

  // bounded wait for the divider; running out ends the run as a failure
  task automatic wait_ready(output int n);
    for (n = 0; n < 40 && op_ready !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
    if (n == 40)
    begin
      fails++;
      close_out();
    end
  endtask

  task automatic t_div;
    int n;
    @(posedge ref_clk);
    issue(MAU_OP_DIVU, 1'b0, 32'h0000_0064, 32'h0000_0007, 5'h00);
    idle();
    wait_ready(n);
    chk32("div_cycles", MAU_DIV_CYC, n);
    chk32("div_ready", 32'h1, {31'h0, op_ready});
    pair(32'h0000_0002, 32'h0000_000e);
    @(posedge ref_clk);
    issue(MAU_OP_DIV, 1'b1, 32'hffff_ff9c, 32'h0000_0007, 5'h00);
    idle();
    wait_ready(n);
    chk32("sdiv_cycles", MAU_DIV_CYC, n);
    pair(32'hffff_fffe, 32'hffff_fff2);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever
      #2 ref_clk = ~ref_clk;
  end

  initial
  begin
    fails = 0;
    check_count = 0;
    rst = 1'b1;
    op_valid = 1'b0;
    op_code = 4'h0;
    op_signed = 1'b0;
    src_a = 32'h0;
    src_b = 32'h0;
    dest_reg = 5'h00;
    repeat (5) @(posedge ref_clk);
    #1;
    chk32("rst_ready", 32'h1, {31'h0, op_ready});
    chk32("rst_we", 32'h0, {31'h0, gpr_we});
    pair(MAU_TOP_RST, MAU_BOT_RST);
    @(posedge ref_clk);
    rst <= 1'b0;
    t_mult();
    t_moves();
    t_accum();
    t_div();
    close_out();
  end
endmodule
